// *** hdl/fhr_pkg.sv ***
// shared constants and types for the flash hold/reset/write-protect ends
// assumes a single 20 MHz system clock on both ends
`default_nettype none
package fhr_pkg;
	// ****************
	// timing
	// ****************
	localparam int CLK_MHZ = 20;
	localparam int SW_RST_NS = 28000;
	localparam int SW_RST_CYC = SW_RST_NS * CLK_MHZ / 1000;
	localparam int PIN_RST_NS = 1000;
	localparam int PIN_RST_CYC = (PIN_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int PU_DLY_NS = 10000;
	localparam int PU_DLY_CYC = (PU_DLY_NS * CLK_MHZ + 999) / 1000;
	localparam int OP_CYC = 100;
	localparam int SCLK_HALF = 8;
	localparam int TMR_W = 10;
	// ****************
	// status bit positions and values
	// ****************
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP = 2;
	localparam int SR_TB = 5;
	localparam int SR_SEC = 6;
	localparam int SR_SRP0 = 7;
	localparam int SR_SRP1 = 8;
	localparam int SR_QE = 9;
	localparam int SR_CMP = 14;
	localparam int SR_SUS = 15;
	localparam int SR_HOLDRST = 23;
	localparam logic [23:0] SR_RESET = 24'h000000;
	localparam logic [23:0] SR_WMASK = 24'h8043fc;
	// ****************
	// instruction codes
	// ****************
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR1 = 8'h05;
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_RDSR3 = 8'h15;
	localparam logic [7:0] CMD_SE = 8'h20;
	localparam logic [7:0] CMD_RDSR2 = 8'h35;
	localparam logic [7:0] CMD_QPI_ON = 8'h38;
	localparam logic [7:0] CMD_RSTEN = 8'h66;
	localparam logic [7:0] CMD_SUSP = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7a;
	localparam logic [7:0] CMD_RST = 8'h99;
	localparam logic [7:0] CMD_RPD = 8'hab;
	localparam logic [7:0] CMD_PD = 8'hb9;
	localparam logic [7:0] CMD_CE = 8'hc7;
	localparam logic [7:0] CMD_BE = 8'hd8;
	localparam logic [7:0] CMD_QPI_OFF = 8'hff;
	// ****************
	// controller registers
	// ****************
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_TXD = 2'h1;
	localparam logic [1:0] REG_RXD = 2'h2;
	localparam logic [1:0] REG_PINS = 2'h3;
	localparam int CTRL_NTX = 8;
	localparam int CTRL_NRX = 10;
	localparam int CTRL_GO = 31;
	localparam int PIN_HOLD = 0;
	localparam int PIN_WP = 1;
	localparam int PIN_RSTP = 2;
	localparam int PIN_OE = 3;
	localparam logic [3:0] PINS_RESET = 4'ha;
	localparam logic [4:0] DEV_SYNC_RST = 5'h0b; // idle levels of sclk, cs_n, di, io3, wp_n
	// ****************
	// state encodings
	// ****************
	typedef enum logic [1:0] {
		HLD_RUN = 2'b00, HLD_ENTER = 2'b01, HLD_ON = 2'b11, HLD_EXIT = 2'b10
	} fhr_hold_t;
	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00, ENG_SETUP = 2'b01, ENG_RUN = 2'b11, ENG_DONE = 2'b10
	} fhr_eng_t;
endpackage : fhr_pkg
`default_nettype wire

// *** hdl/fhr_link_if.sv ***
// serial flash bus between controller and device
// assumes pull-ups on the data-out and shared hold/reset lines
`default_nettype none
interface fhr_link_if;
	logic sclk;
	logic cs_n;
	logic di;
	logic dout_o;
	logic dout_oe;
	logic io3_o;
	logic io3_oe;
	logic wp_n;
	logic dout;
	logic io3;
	// ****************
	// wire levels from the enables
	// ****************
	assign dout = dout_oe ? dout_o : 1'b1;
	assign io3 = io3_oe ? io3_o : 1'b1;
	modport dev (input sclk, cs_n, di, io3, wp_n, output dout_o, dout_oe);
	modport host (output sclk, cs_n, di, io3_o, io3_oe, wp_n, input dout);
endinterface : fhr_link_if
`default_nettype wire

// *** hdl/fhr_sync.sv ***
// two-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no bus coherence is implied
`default_nettype none
module fhr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} fhr_sync_st_t;
	fhr_sync_st_t s_r, s_nxt;
	// first stage feeds only the second
	always_comb begin
		s_nxt.s1 = d;
		s_nxt.s2 = s_r.s1;
	end
	// resets to each line's idle level so no false edge follows reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{s1: RST_VAL, s2: RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end
	assign q = s_r.s2;
endmodule : fhr_sync
`default_nettype wire

// *** hdl/fhr_dev.sv ***
// flash device end: pause, software/pin reset and write-protect gating
// assumes the controller runs the bus in mode 0, slower than hclk / 8
`default_nettype none
module fhr_dev
	import fhr_pkg::*;
(
	input wire logic hclk, // system clock
	input wire logic hresetn, // async, active low; stands for supply-low reset
	fhr_link_if.dev lnk, // flash bus
	output logic [23:0] status, // all three status bytes
	output logic paused, // pause in force
	output logic [2:0] block_protect_field, // protected portion size
	output logic top_bottom_select, // 1: protect from bottom
	output logic small_unit_protect, // 1: 4KB units, 0: 64KB units
	output logic complement_protect, // inverts protected region
	output logic write_enable_latch, // latch state
	output logic op_busy, // internal program/erase/status write
	output logic powered_down, // power-down state
	output logic in_reset // software reset recovery
);
	typedef struct packed {
		logic [23:0] sr;
		logic [23:0] wrd;
		logic [7:0] sh;
		logic [7:0] cmd;
		logic [7:0] osh;
		logic [2:0] bitn;
		logic [2:0] nbyte;
		fhr_hold_t hold;
		logic dout;
		logic oen;
		logic rst_en;
		logic pd;
		logic four_wire_command_mode;
		logic recov;
		logic [TMR_W-1:0] tmr;
		logic [TMR_W-1:0] pu;
		logic sclk_q;
		logic cs_q;
		logic io3_q;
	} fhr_dev_st_t;

	fhr_dev_st_t s_r, s_nxt;
	logic [4:0] sy;
	logic sclk, cs_n, di, io3, wp_n;
	logic rise, fall, cs_up, hold_fn, rst_fn, halt, wr_ok;
	logic [7:0] shv;
	logic [23:0] m;

	// ****************
	// input synchronisation
	// ****************
	fhr_sync #(.W(5), .RST_VAL(DEV_SYNC_RST)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({lnk.sclk, lnk.cs_n, lnk.di, lnk.io3, lnk.wp_n}),
		.q(sy)
	);
	assign {sclk, cs_n, di, io3, wp_n} = sy;

	// status read instructions
	function automatic logic is_rd(input logic [7:0] c);
		return c == CMD_RDSR1 || c == CMD_RDSR2 || c == CMD_RDSR3;
	endfunction : is_rd

	// ****************
	// next state
	// ****************
	always_comb begin
		s_nxt = s_r;
		m = '0;
		rise = sclk & ~s_r.sclk_q;
		fall = ~sclk & s_r.sclk_q;
		cs_up = cs_n & ~s_r.cs_q;
		hold_fn = ~s_r.sr[SR_QE] & ~s_r.four_wire_command_mode & ~s_r.sr[SR_HOLDRST];
		rst_fn = ~s_r.sr[SR_QE] & ~s_r.four_wire_command_mode & s_r.sr[SR_HOLDRST];
		halt = s_r.hold == HLD_ON || s_r.hold == HLD_EXIT;
		shv = {s_r.sh[6:0], di};
		wr_ok = s_r.sr[SR_WEL] && s_r.pu == '0 && !s_r.sr[SR_SRP1]
			&& (!s_r.sr[SR_SRP0] || wp_n || s_r.sr[SR_QE] || s_r.four_wire_command_mode);
		s_nxt.sclk_q = sclk;
		s_nxt.cs_q = cs_n;
		s_nxt.io3_q = io3;
		if (s_r.pu != '0) begin
			s_nxt.pu = s_r.pu - 1'b1;
		end
		// op and recovery timer; suspend freezes it
		if (s_r.recov || (s_r.sr[SR_BUSY] && !s_r.sr[SR_SUS])) begin
			if (s_r.tmr != '0) begin
				s_nxt.tmr = s_r.tmr - 1'b1;
			end else begin
				s_nxt.recov = 1'b0;
				s_nxt.sr[SR_BUSY] = 1'b0;
			end
		end
		// pause entry and exit against the clock level
		case (s_r.hold)
			HLD_RUN: s_nxt.hold = (!io3 && s_r.io3_q) ? (sclk ? HLD_ENTER : HLD_ON) : HLD_RUN;
			HLD_ENTER: s_nxt.hold = fall ? HLD_ON : io3 ? HLD_RUN : HLD_ENTER;
			HLD_ON: s_nxt.hold = (io3 && !s_r.io3_q) ? (sclk ? HLD_EXIT : HLD_RUN) : HLD_ON;
			HLD_EXIT: s_nxt.hold = fall ? HLD_RUN : HLD_EXIT;
			default: s_nxt.hold = HLD_RUN;
		endcase
		// pause is undefined while deselected, so it simply drops
		if (cs_n || !hold_fn) begin
			s_nxt.hold = HLD_RUN;
		end
		// shifting frozen while paused, progress kept
		if (!cs_n && !halt && !s_r.recov) begin
			if (rise) begin
				s_nxt.sh = shv;
				s_nxt.bitn = s_r.bitn + 1'b1;
				if (s_r.bitn == 3'd7) begin
					case (s_r.nbyte)
						3'd0: begin
							s_nxt.cmd = shv;
							s_nxt.osh = shv == CMD_RDSR2 ? s_r.sr[15:8]
								: shv == CMD_RDSR3 ? s_r.sr[23:16] : s_r.sr[7:0];
						end
						3'd1: s_nxt.wrd[7:0] = shv;
						3'd2: s_nxt.wrd[15:8] = shv;
						default: s_nxt.wrd[23:16] = shv;
					endcase
					if (s_r.nbyte != 3'd4) begin
						s_nxt.nbyte = s_r.nbyte + 1'b1;
					end
				end
			end
			// status streams out repeatedly on falling edges
			if (fall && s_r.nbyte != 3'd0 && is_rd(s_r.cmd) && !s_r.pd) begin
				s_nxt.dout = s_r.osh[7];
				s_nxt.osh = {s_r.osh[6:0], s_r.osh[7]};
				s_nxt.oen = 1'b1;
			end
		end
		// deselect clears instruction progress, even mid-pause
		if (cs_n) begin
			{s_nxt.bitn, s_nxt.nbyte} = '0;
			s_nxt.oen = 1'b0;
		end
		// whole-byte instructions act when select rises
		if (cs_up && s_r.nbyte != 3'd0 && s_r.bitn == 3'd0 && !halt && !s_r.recov) begin
			// enable survives only into the next command
			s_nxt.rst_en = 1'b0;
			if (s_r.pd) begin
				s_nxt.pd = s_r.cmd != CMD_RPD;
			end else if (s_r.sr[SR_BUSY]) begin
				if (s_r.cmd == CMD_SUSP) begin
					s_nxt.sr[SR_SUS] = 1'b1;
				end else if (s_r.cmd == CMD_RESUME) begin
					s_nxt.sr[SR_SUS] = 1'b0;
				end
			end else begin
				case (s_r.cmd)
					CMD_RSTEN: s_nxt.rst_en = 1'b1;
					CMD_RST: begin
						if (s_r.rst_en) begin
							s_nxt.sr[SR_WEL] = 1'b0;
							s_nxt.sr[SR_SUS] = 1'b0;
							s_nxt.pd = 1'b0;
							s_nxt.four_wire_command_mode = 1'b0;
							s_nxt.recov = 1'b1;
							s_nxt.tmr = TMR_W'(SW_RST_CYC);
						end
					end
					CMD_WREN: begin
						if (s_r.pu == '0) begin
							s_nxt.sr[SR_WEL] = 1'b1;
						end
					end
					CMD_WRDI: s_nxt.sr[SR_WEL] = 1'b0;
					CMD_WRSR: begin
						if (wr_ok) begin
							m = s_r.nbyte == 3'd2 ? 24'h0000ff
								: s_r.nbyte == 3'd3 ? 24'h00ffff : 24'hffffff;
							m = m & SR_WMASK;
							// quad bit cannot be cleared from four-wire mode
							m[SR_QE] = m[SR_QE] & ~s_r.four_wire_command_mode;
							s_nxt.sr = (s_r.sr & ~m) | (s_r.wrd & m);
							s_nxt.sr[SR_BUSY] = 1'b1;
							s_nxt.sr[SR_WEL] = 1'b0;
							s_nxt.tmr = TMR_W'(OP_CYC);
						end
					end
					CMD_PP, CMD_SE, CMD_BE, CMD_CE: begin
						if (s_r.sr[SR_WEL] && s_r.pu == '0) begin
							s_nxt.sr[SR_BUSY] = 1'b1;
							s_nxt.sr[SR_WEL] = 1'b0;
							s_nxt.tmr = TMR_W'(OP_CYC);
						end
					end
					CMD_PD: s_nxt.pd = 1'b1;
					CMD_QPI_ON: s_nxt.four_wire_command_mode = s_r.sr[SR_QE];
					CMD_QPI_OFF: s_nxt.four_wire_command_mode = 1'b0;
					default: s_nxt.rst_en = 1'b0;
				endcase
			end
		end
		// reset pin low beats everything else
		if (rst_fn && !io3) begin
			{s_nxt.bitn, s_nxt.nbyte, s_nxt.tmr} = '0;
			{s_nxt.oen, s_nxt.rst_en, s_nxt.pd, s_nxt.four_wire_command_mode, s_nxt.recov} = '0;
			s_nxt.sr[SR_WEL:SR_BUSY] = 2'b00;
			s_nxt.sr[SR_SUS] = 1'b0;
			s_nxt.hold = HLD_RUN;
		end
	end

	// state register; power-up delay loads at reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{sr: SR_RESET, hold: HLD_RUN, pu: TMR_W'(PU_DLY_CYC),
				sclk_q: 1'b0, cs_q: 1'b1, io3_q: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************
	// outputs
	// ****************
	// output floats while paused or deselected
	assign lnk.dout_oe = s_r.oen & ~cs_n & ~halt;
	assign lnk.dout_o = s_r.dout;
	assign status = s_r.sr;
	assign paused = halt;
	assign block_protect_field = s_r.sr[SR_BP +: 3];
	assign top_bottom_select = s_r.sr[SR_TB];
	assign small_unit_protect = s_r.sr[SR_SEC];
	assign complement_protect = s_r.sr[SR_CMP];
	assign write_enable_latch = s_r.sr[SR_WEL];
	assign op_busy = s_r.sr[SR_BUSY];
	assign powered_down = s_r.pd;
	assign in_reset = s_r.recov;
endmodule : fhr_dev
`default_nettype wire

// *** hdl/fhr_host.sv ***
// flash bus controller: AHB-Lite registers drive a mode-0 serial engine
// assumes one AHB master; zero wait states, always OKAY
`default_nettype none
module fhr_host
	import fhr_pkg::*;
(
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write access
	input wire logic [2:0] hsize, // word only
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // always ready
	output logic hresp, // always OKAY
	fhr_link_if.host lnk // flash bus
);
	typedef struct packed {
		logic [7:0] cmd;
		logic [1:0] ntx;
		logic [1:0] nrx;
		logic [23:0] txd;
		logic [23:0] rxd;
		logic [3:0] pins;
		logic [31:0] obuf;
		logic [5:0] nbit;
		logic [3:0] div;
		fhr_eng_t st;
		logic sclk;
		logic cs_n;
		logic [TMR_W-1:0] rcnt;
		logic aw;
		logic [1:0] aidx;
		logic [31:0] rdata;
	} fhr_host_st_t;

	fhr_host_st_t s_r, s_nxt;
	logic dout_s, tick, hold_act, hit;

	fhr_sync #(.W(1)) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(lnk.dout),
		.q(dout_s)
	);

	// pause only mid-frame at clock low; frame frozen meanwhile
	assign hold_act = s_r.pins[PIN_HOLD] && s_r.st == ENG_RUN && !s_r.sclk;
	assign tick = s_r.div == 4'(SCLK_HALF - 1);
	assign hit = hsel && hready && htrans[1] && haddr[31:4] == '0;

	// ****************
	// next state
	// ****************
	always_comb begin
		s_nxt = s_r;
		s_nxt.div = (tick || s_r.st == ENG_IDLE || hold_act) ? '0 : s_r.div + 1'b1;
		// reset pulse held its full length
		if (s_r.rcnt != '0) begin
			s_nxt.rcnt = s_r.rcnt - 1'b1;
		end
		// address phase: decode, capture read data
		s_nxt.aw = hit && hwrite;
		s_nxt.aidx = haddr[3:2];
		if (hit && !hwrite) begin
			case (haddr[3:2])
				REG_CTRL: s_nxt.rdata = {s_r.st != ENG_IDLE, 19'h0, s_r.nrx, s_r.ntx, s_r.cmd};
				REG_TXD: s_nxt.rdata = {8'h00, s_r.txd};
				REG_RXD: s_nxt.rdata = {8'h00, s_r.rxd};
				default: s_nxt.rdata = {24'h0, 1'b0, hold_act, s_r.rcnt != '0, s_r.st != ENG_IDLE, s_r.pins};
			endcase
		end else begin
			s_nxt.rdata = '0;
		end
		// data phase of a write
		if (s_r.aw) begin
			case (s_r.aidx)
				REG_CTRL: begin
					// frames are not queued: a start while running is dropped
					if (hwdata[CTRL_GO] && s_r.st == ENG_IDLE) begin
						s_nxt.cmd = hwdata[7:0];
						s_nxt.ntx = hwdata[CTRL_NTX +: 2];
						s_nxt.nrx = hwdata[CTRL_NRX +: 2];
						s_nxt.obuf = {hwdata[7:0], s_r.txd[7:0], s_r.txd[15:8], s_r.txd[23:16]};
						s_nxt.nbit = {3'(3'd1 + {1'b0, hwdata[CTRL_NTX +: 2]}
							+ {1'b0, hwdata[CTRL_NRX +: 2]}), 3'b000};
						s_nxt.cs_n = 1'b0;
						s_nxt.st = ENG_SETUP;
					end
				end
				REG_TXD: s_nxt.txd = hwdata[23:0];
				REG_PINS: begin
					s_nxt.pins = {hwdata[PIN_OE], 1'b0, hwdata[PIN_WP], hwdata[PIN_HOLD]};
					if (hwdata[PIN_RSTP]) begin
						s_nxt.rcnt = TMR_W'(PIN_RST_CYC);
					end
				end
				default: s_nxt.pins = s_r.pins;
			endcase
		end
		// serial engine, mode 0
		case (s_r.st)
			ENG_IDLE: s_nxt.sclk = 1'b0;
			ENG_SETUP: begin
				if (tick) begin
					s_nxt.st = ENG_RUN;
				end
			end
			ENG_RUN: begin
				if (tick) begin
					s_nxt.sclk = ~s_r.sclk;
					if (!s_r.sclk) begin
						s_nxt.rxd = {s_r.rxd[22:0], dout_s};
					end else begin
						s_nxt.obuf = {s_r.obuf[30:0], 1'b0};
						s_nxt.nbit = s_r.nbit - 1'b1;
						if (s_r.nbit == 6'd1) begin
							s_nxt.st = ENG_DONE;
						end
					end
				end
			end
			ENG_DONE: begin
				if (tick) begin
					s_nxt.cs_n = 1'b1;
					s_nxt.st = ENG_IDLE;
				end
			end
			default: s_nxt.st = ENG_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= '{pins: PINS_RESET, st: ENG_IDLE, cs_n: 1'b1, default: '0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************
	// outputs
	// ****************
	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign lnk.sclk = s_r.sclk;
	assign lnk.cs_n = s_r.cs_n;
	assign lnk.di = s_r.obuf[31];
	assign lnk.wp_n = s_r.pins[PIN_WP];
	// reset pulse wins the shared pin over pause
	assign lnk.io3_o = s_r.rcnt == '0 && !hold_act;
	assign lnk.io3_oe = s_r.pins[PIN_OE] || s_r.rcnt != '0;
endmodule : fhr_host
`default_nettype wire

// *** test/fhr_properties.sv ***
// concurrent checks on the flash link and the device flags
// assumes the bench places it beside the link interface
`default_nettype none
module fhr_properties
	import fhr_pkg::*;
(
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic sclk, // serial clock
	input wire logic cs_n, // select, active low
	input wire logic dout_oe, // device drives data out
	input wire logic io3, // shared pin level
	input wire logic io3_oe, // host drives shared pin
	input wire logic [23:0] status, // device status bytes
	input wire logic paused, // pause in force
	input wire logic in_reset, // software reset recovery
	input wire logic op_busy // internal operation
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [9:0] up_r;
	logic [9:0] rec_r;
	// ****************
	// helper counters
	// ****************
	// age saturates so a long run never wraps back into the delay window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			up_r <= 10'h000;
			rec_r <= 10'h000;
		end else begin
			up_r <= (up_r == 10'h3ff) ? up_r : up_r + 10'h001;
			rec_r <= in_reset ? rec_r + 10'h001 : 10'h000;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ****************
	// properties
	// ****************
	sequence pause_fall;
		$fell(io3) && !sclk && !cs_n && !status[SR_QE] && !status[SR_HOLDRST];
	endsequence
	sequence pause_rise;
		$rose(io3) && paused && !sclk;
	endsequence
	sequence pin_pulse;
		$fell(io3) && io3_oe && status[SR_HOLDRST] && !status[SR_QE];
	endsequence
	a_pause_enters: assert property (pause_fall |-> ##[1:8] paused)
		else $error("pause not entered");
	a_pause_leaves: assert property (pause_rise |-> ##[1:8] !paused)
		else $error("pause not left");
	a_pause_floats: assert property (paused |-> !dout_oe)
		else $error("output driven in pause");
	a_pause_keeps: assert property (paused && !op_busy |=> $stable(status))
		else $error("status moved in pause");
	a_pause_gated: assert property ($rose(paused) |->
		!cs_n && !status[SR_QE] && !status[SR_HOLDRST]) else $error("pause when disabled");
	a_host_pause: assert property ($fell(io3) && io3_oe && !status[SR_HOLDRST] |->
		!cs_n && !sclk) else $error("pause outside a frame");
	a_pause_selected: assert property (paused |-> !cs_n)
		else $error("select dropped in pause");
	a_powerup_wel: assert property ($rose(status[SR_WEL]) |-> up_r >= PU_DLY_CYC)
		else $error("latch set in power-up delay");
	a_wel_needed: assert property ($rose(op_busy) |->
		$past(status[SR_WEL]) || $past(status[SR_WEL], 2)) else $error("write without latch");
	a_done_clears: assert property ($fell(op_busy) |-> ##[0:1] !status[SR_WEL])
		else $error("latch kept after write");
	a_busy_no_wren: assert property ($rose(status[SR_WEL]) |-> !$past(op_busy))
		else $error("enable taken while busy");
	a_recovery_len: assert property ($fell(in_reset) |->
		rec_r >= SW_RST_CYC - 1 && rec_r <= SW_RST_CYC + 1) else $error("recovery length");
	a_recovery_quiet: assert property (in_reset && $past(in_reset) |->
		!status[SR_WEL] && !op_busy) else $error("activity in recovery");
	a_pin_resets: assert property (pin_pulse |-> ##[1:8] !status[SR_WEL] && !op_busy)
		else $error("pin reset ignored");
endmodule : fhr_properties
`default_nettype wire

// *** test/flash_hold_reset_write_protect_test.sv ***
// bench: controller and device back to back, driven over AHB-Lite
// assumes controller register map and codes from the shared package
`default_nettype none
module flash_hold_reset_write_protect_test
	import fhr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic cmp_bit;
	logic [23:0] status;
	logic paused;
	logic [2:0] prot;
	logic top_sel;
	logic small_unit;
	logic latch;
	logic op_busy;
	logic pdown;
	logic in_reset;
	logic [31:0] rdv;
	int n_errors = 0;
	int compares = 0;
	// ****************
	// wiring
	// ****************
	always #25 hclk = ~hclk;
	fhr_link_if fhr_link_if_i ();
	fhr_host fhr_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(fhr_link_if_i.host));
	fhr_dev fhr_dev_i (.hclk(hclk), .hresetn(hresetn), .lnk(fhr_link_if_i.dev), .status(status),
		.paused(paused), .block_protect_field(prot), .top_bottom_select(top_sel),
		.small_unit_protect(small_unit), .complement_protect(cmp_bit), .write_enable_latch(latch),
		.op_busy(op_busy), .powered_down(pdown), .in_reset(in_reset));
	fhr_properties fhr_properties_i (.hclk(hclk), .hresetn(hresetn), .sclk(fhr_link_if_i.sclk),
		.cs_n(fhr_link_if_i.cs_n), .dout_oe(fhr_link_if_i.dout_oe), .io3(fhr_link_if_i.io3),
		.io3_oe(fhr_link_if_i.io3_oe), .status(status), .paused(paused), .in_reset(in_reset),
		.op_busy(op_busy));
	// ****************
	// tasks
	// ****************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic results();
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic bail();
		n_errors++;
		results();
	endtask : bail
	// bounded wait for a flag level, one look per edge
	task automatic wait_for(ref logic s, input logic v);
		int i;
		i = 0;
		while (s !== v && i < 1000) begin
			@(posedge hclk);
			i++;
		end
		if (s !== v) bail();
	endtask : wait_for
	function automatic logic [31:0] ra(input logic [1:0] r);
		return {28'h0, r, 2'h0};
	endfunction : ra
	// single word transfer; address held until ready, then data phase
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		wait_for(hreadyout, 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		wait_for(hreadyout, 1'b1);
		rdv = hrdata;
	endtask : bus
	task automatic go(input logic [7:0] c, input logic [1:0] nt, input logic [1:0] nr,
		input logic [23:0] d);
		bus(1'b1, ra(REG_TXD), {8'h00, d});
		bus(1'b1, ra(REG_CTRL), {1'b1, 19'h0, nr, nt, c});
	endtask : go
	// poll the engine idle, then fetch received bytes
	task automatic fin();
		int i;
		i = 0;
		do begin
			bus(1'b0, ra(REG_CTRL), 32'h0);
			i++;
		end while (rdv[31] !== 1'b0 && i < 400);
		if (i >= 400) bail();
		bus(1'b0, ra(REG_RXD), 32'h0);
	endtask : fin
	task automatic cmd(input logic [7:0] c, input logic [1:0] nt, input logic [23:0] d);
		go(c, nt, 2'h0, d);
		fin();
	endtask : cmd
	task automatic rdsr(input logic [7:0] exp);
		cmd(CMD_RDSR1, 2'h0, 24'h0);
		go(CMD_RDSR1, 2'h0, 2'h1, 24'h0);
		fin();
		check("status", 32'(rdv[7:0]), 32'(exp));
	endtask : rdsr
	task automatic wrsr(input logic [1:0] nt, input logic [23:0] d);
		cmd(CMD_WREN, 2'h0, 24'h0);
		cmd(CMD_WRSR, nt, d);
		check("busy", 32'(op_busy), 32'h1);
		wait_for(op_busy, 1'b0);
	endtask : wrsr
	// status read with a pause requested in mid-byte, then released
	task automatic paused_read(input logic exp);
		go(CMD_RDSR1, 2'h0, 2'h1, 24'h0);
		// lands inside the status byte, while the device drives its output
		repeat (180) @(posedge hclk);
		bus(1'b1, ra(REG_PINS), 32'h0b);
		repeat (40) @(posedge hclk);
		check("paused", 32'(paused), 32'(exp));
		check("float", 32'(fhr_link_if_i.dout_oe), 32'(!exp));
		bus(1'b1, ra(REG_PINS), 32'h0a);
		fin();
		check("resumed", 32'(rdv[7:0]), 32'h7c);
	endtask : paused_read
	// ****************
	// sequence
	// ****************
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		cmd(CMD_WREN, 2'h0, 24'h0);
		rdsr(8'h00);
		bus(1'b0, ra(REG_PINS), 32'h0);
		check("pins", 32'(rdv[3:0]), 32'(PINS_RESET));
		check("okay", 32'(hresp), 32'h0);
		bus(1'b1, 32'h10, 32'hffffffff);
		bus(1'b0, 32'h10, 32'h0);
		check("unmapped", rdv, 32'h0);
		// latch set and cleared; status write needs the latch
		cmd(CMD_WREN, 2'h0, 24'h0);
		rdsr(8'h02);
		cmd(CMD_WRDI, 2'h0, 24'h0);
		rdsr(8'h00);
		cmd(CMD_WRSR, 2'h1, 24'h00007c);
		rdsr(8'h00);
		wrsr(2'h1, 24'h00007c);
		check("fields", 32'({prot, top_sel, small_unit}), 32'h1f);
		check("latch", 32'(latch), 32'h0);
		// power-down ignores all but release; floating output reads high
		cmd(CMD_PD, 2'h0, 24'h0);
		check("pdown", 32'(pdown), 32'h1);
		cmd(CMD_WREN, 2'h0, 24'h0);
		rdsr(8'hff);
		cmd(CMD_RPD, 2'h0, 24'h0);
		rdsr(8'h7c);
		paused_read(1'b1);
		wrsr(2'h2, 24'h00427c);
		check("quad", 32'({status[SR_QE], cmp_bit}), 32'h3);
		paused_read(1'b0);
		wrsr(2'h2, 24'h00007c);
		// lock bits with write-protect pin low refuse status writes
		wrsr(2'h1, 24'h0000fc);
		bus(1'b1, ra(REG_PINS), 32'h08);
		cmd(CMD_WREN, 2'h0, 24'h0);
		cmd(CMD_WRSR, 2'h1, 24'h0);
		check("locked", 32'({op_busy, status[7:2]}), 32'h3f);
		bus(1'b1, ra(REG_PINS), 32'h0a);
		wrsr(2'h1, 24'h0);
		rdsr(8'h00);
		// reset enable cancelled by another command, then a real reset
		cmd(CMD_WREN, 2'h0, 24'h0);
		cmd(CMD_RSTEN, 2'h0, 24'h0);
		rdsr(8'h02);
		cmd(CMD_RST, 2'h0, 24'h0);
		check("no reset", 32'(in_reset), 32'h0);
		cmd(CMD_RSTEN, 2'h0, 24'h0);
		cmd(CMD_RST, 2'h0, 24'h0);
		check("reset", 32'(in_reset), 32'h1);
		rdsr(8'hff);
		wait_for(in_reset, 1'b0);
		rdsr(8'h00);
		// pin reset aborts a status write in progress
		wrsr(2'h3, 24'h800000);
		check("pin mode", 32'(status[SR_HOLDRST]), 32'h1);
		cmd(CMD_WREN, 2'h0, 24'h0);
		cmd(CMD_WRSR, 2'h3, 24'h800000);
		bus(1'b1, ra(REG_PINS), 32'h0e);
		repeat (30) @(posedge hclk);
		check("aborted", 32'({op_busy, latch}), 32'h0);
		results();
	end
endmodule : flash_hold_reset_write_protect_test
`default_nettype wire
